/* core/rsc_reset_seq.v */
// reset start-up sequencer and reset-cause flag recorder
`include "rsc_defs.vh"

// Notes on behaviour
// - programming mode exit acts as power-on reset
// - enabled power-up timer holds execution after power events
// - timer enabled when bit clear; 64 ms
// - start waits timer, oscillator, and pin release
// - timers ignore pin; run at once on release
// - every reset updates the cause flags
// - power-on: pc zero, fixed flag pattern except brown-out flag kept
// - brown-out: pc zero, power-on flag kept
// - watchdog clears timeout; sleep wake continues
// - interrupt wake continues; vector 0004h if enabled
// - pin reset running clears only pin flag
// - pin reset asleep also sets timeout, clears sleep
// - reset instruction clears its flag, restarts
// - enabled stack overflow sets flag, restarts
// - enabled stack underflow sets flag, restarts
// - flag layout bits 7,6,3..0; 5,4 zero
// - hardware sets stack flags, clears others
// - unimplemented status bits read zero
module rsc_reset_seq #(
	parameter PUT_CYCLES = `RSC_PUT_CYCLES,
	parameter PUT_WIDTH = `RSC_PUT_WIDTH,
	parameter [7:0] CAUSE_IMPL = `RSC_CAUSE_IMPL
) (
	// clock and reset
	input wire clock,
	input wire rst,
	// register port
	input wire [`RSC_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wr_data,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rd_data,
	// reset sources
	input wire por_active,
	input wire bor_active,
	input wire prog_exit,
	input wire ext_reset_pin,
	input wire wdt_expired,
	input wire reset_instr_exec,
	input wire stack_overflow,
	input wire stack_underflow,
	input wire irq_wake,
	// core context
	input wire in_sleep,
	input wire global_irq_enable,
	input wire osc_start_done,
	// core control
	output reg core_hold,
	output reg pc_load,
	output reg [`RSC_PC_W-1:0] pc_load_addr,
	output reg wake_continue,
	output reg push_return,
	// status bits
	output reg watchdog_timeout_flag,
	output reg sleep_entry_flag
);

	////////////////////////////////////////////////////////////////////////
	// sequencer states
	localparam [1:0] ST_POWER = 2'b00;
	localparam [1:0] ST_STARTUP = 2'b01;
	localparam [1:0] ST_RUN = 2'b10;
	localparam [1:0] ST_PINHOLD = 2'b11;

	////////////////////////////////////////////////////////////////////////
	// state and registers
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [7:0] power_control_reg;
	reg [7:0] power_control_next;
	reg [7:0] ctrl_reg;
	reg [7:0] ctrl_next;
	reg timeout_next;
	reg sleep_next;
	reg timer_start;
	reg restart;
	reg wake;
	reg push;
	reg hold_next;
	reg pc_load_next;
	reg [`RSC_PC_W-1:0] pc_addr_next;
	reg [7:0] rd_next;

	wire put_busy;
	wire put_done;
	wire power_up_delay_enable_n;
	wire ext_pin_enable;
	wire stack_error_reset_enable;
	wire osc_required;
	wire pin_low;
	wire put_ok;
	wire osc_ok;

	////////////////////////////////////////////////////////////////////////
	// address decode shared by reads and writes
	function hit;
		input [`RSC_ADDR_W-1:0] addr;
		input [`RSC_ADDR_W-1:0] offset;
		begin
			hit = (addr == offset);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// configuration bits
	assign power_up_delay_enable_n = ctrl_reg[`RSC_B_PUT_EN_N];
	assign ext_pin_enable = ctrl_reg[`RSC_B_PIN_EN];
	assign stack_error_reset_enable = ctrl_reg[`RSC_B_STK_EN];
	assign osc_required = ctrl_reg[`RSC_B_OSC_REQ];

	// pin held low only counts when the pin function is enabled
	assign pin_low = ext_pin_enable & ~ext_reset_pin;
	assign put_ok = power_up_delay_enable_n | put_done;
	assign osc_ok = ~osc_required | osc_start_done;

	////////////////////////////////////////////////////////////////////////
	// power-up delay timer; counts whatever the pin does
	rsc_delay_timer #(
		.WIDTH(PUT_WIDTH),
		.CYCLES(PUT_CYCLES)
	) u_put (
		.clock(clock),
		.rst(rst),
		.start(timer_start),
		.busy(put_busy),
		.done(put_done)
	);

	////////////////////////////////////////////////////////////////////////
	// next-state and flag logic
	always @* begin
		state_next = state_reg;
		power_control_next = power_control_reg;
		ctrl_next = ctrl_reg;
		timeout_next = watchdog_timeout_flag;
		sleep_next = sleep_entry_flag;
		timer_start = 1'b0;
		restart = 1'b0;
		wake = 1'b0;
		push = 1'b0;

		// firmware writes land first so a hardware event below wins
		if (reg_wr && hit(reg_addr, `RSC_OFF_CAUSE)) begin
			power_control_next = reg_wr_data & CAUSE_IMPL;
		end
		if (reg_wr && hit(reg_addr, `RSC_OFF_CTRL)) begin
			ctrl_next = reg_wr_data;
		end

		if (por_active || prog_exit) begin
			// brown-out flag is undefined here and simply kept
			power_control_next[`RSC_B_OVF] = 1'b0;
			power_control_next[`RSC_B_UNF] = 1'b0;
			power_control_next[`RSC_B_PIN] = 1'b1;
			power_control_next[`RSC_B_INSTR] = 1'b1;
			power_control_next[`RSC_B_POR] = 1'b0;
			timeout_next = 1'b1;
			sleep_next = 1'b1;
			state_next = ST_POWER;
		end else if (bor_active) begin
			power_control_next[`RSC_B_OVF] = 1'b0;
			power_control_next[`RSC_B_UNF] = 1'b0;
			power_control_next[`RSC_B_PIN] = 1'b1;
			power_control_next[`RSC_B_INSTR] = 1'b1;
			power_control_next[`RSC_B_BOR] = 1'b0;
			timeout_next = 1'b1;
			sleep_next = 1'b1;
			state_next = ST_POWER;
		end else begin
			case (state_reg)
			ST_POWER: begin
				// supply released: start the delay from here
				timer_start = 1'b1;
				state_next = ST_STARTUP;
			end
			ST_STARTUP: begin
				if (put_ok && osc_ok && !pin_low) begin
					state_next = ST_RUN;
					restart = 1'b1;
				end
			end
			ST_RUN: begin
				if (pin_low) begin
					power_control_next[`RSC_B_PIN] = 1'b0;
					if (in_sleep) begin
						timeout_next = 1'b1;
						sleep_next = 1'b0;
					end
					state_next = ST_PINHOLD;
				end else begin
					if (wdt_expired) begin
						timeout_next = 1'b0;
						if (in_sleep) begin
							sleep_next = 1'b0;
							wake = 1'b1;
						end else begin
							restart = 1'b1;
						end
					end else if (irq_wake && in_sleep) begin
						timeout_next = 1'b1;
						sleep_next = 1'b0;
						wake = 1'b1;
						push = global_irq_enable;
					end
					if (reset_instr_exec) begin
						power_control_next[`RSC_B_INSTR] = 1'b0;
						restart = 1'b1;
					end
					if (stack_overflow && stack_error_reset_enable) begin
						power_control_next[`RSC_B_OVF] = 1'b1;
						restart = 1'b1;
					end
					if (stack_underflow && stack_error_reset_enable) begin
						power_control_next[`RSC_B_UNF] = 1'b1;
						restart = 1'b1;
					end
				end
			end
			ST_PINHOLD: begin
				if (!pin_low) begin
					state_next = ST_RUN;
					restart = 1'b1;
				end
			end
			default: begin
				state_next = ST_POWER;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core-facing outputs; a restart's reset vector wins over a wake's interrupt vector in one cycle
	always @* begin
		hold_next = (state_next != ST_RUN) | restart;
		pc_load_next = restart | push;
		if (restart) begin
			pc_addr_next = `RSC_VEC_RESET;
		end else if (push) begin
			pc_addr_next = `RSC_VEC_IRQ;
		end else begin
			pc_addr_next = pc_load_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; bits 5 and 4 and unbuilt bits zero except for the control register, which reads back whole
	always @* begin
		rd_next = 8'h00;
		if (reg_rd) begin
			if (hit(reg_addr, `RSC_OFF_CAUSE)) begin
				rd_next = power_control_reg & CAUSE_IMPL;
			end else if (hit(reg_addr, `RSC_OFF_STATUS)) begin
				rd_next[`RSC_B_TO] = watchdog_timeout_flag;
				rd_next[`RSC_B_PD] = sleep_entry_flag;
			end else if (hit(reg_addr, `RSC_OFF_SEQ)) begin
				rd_next[`RSC_B_HOLD] = core_hold;
				rd_next[`RSC_B_STARTUP] = (state_reg == ST_STARTUP);
				rd_next[`RSC_B_PUT_BUSY] = put_busy;
			end else if (hit(reg_addr, `RSC_OFF_CTRL)) begin
				rd_next = ctrl_reg;
			end else begin
				rd_next = 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers; rst is treated as a power-on reset
	always @(posedge clock) begin
		if (rst) begin
			state_reg <= ST_POWER;
			power_control_reg <= `RSC_CAUSE_POR;
			ctrl_reg <= `RSC_CTRL_RESET;
			watchdog_timeout_flag <= 1'b1;
			sleep_entry_flag <= 1'b1;
			core_hold <= 1'b1;
			pc_load <= 1'b0;
			pc_load_addr <= `RSC_VEC_RESET;
			wake_continue <= 1'b0;
			push_return <= 1'b0;
			reg_rd_data <= 8'h00;
		end else begin
			state_reg <= state_next;
			// flags untouched by an event keep their value
			power_control_reg <= power_control_next & CAUSE_IMPL;
			ctrl_reg <= ctrl_next;
			watchdog_timeout_flag <= timeout_next;
			sleep_entry_flag <= sleep_next;
			core_hold <= hold_next;
			pc_load <= pc_load_next;
			pc_load_addr <= pc_addr_next;
			wake_continue <= wake;
			push_return <= push;
			reg_rd_data <= rd_next;
		end
	end

endmodule

/* core/rsc_defs.vh */
// constants for the reset start-up sequencer and reset-cause flags
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// clock and power-up delay timing
`define RSC_CLK_HZ 10000000
`define RSC_PUT_MS 64
`define RSC_PUT_CYCLES ((`RSC_PUT_MS * `RSC_CLK_HZ) / 1000)
`define RSC_PUT_WIDTH 20

// register offsets
`define RSC_ADDR_W 4
`define RSC_OFF_CAUSE 4'h0
`define RSC_OFF_STATUS 4'h1
`define RSC_OFF_SEQ 4'h2
`define RSC_OFF_CTRL 4'h3

// power control register fields
`define RSC_B_OVF 7
`define RSC_B_UNF 6
`define RSC_B_PIN 3
`define RSC_B_INSTR 2
`define RSC_B_POR 1
`define RSC_B_BOR 0
`define RSC_CAUSE_IMPL 8'hCF
`define RSC_CAUSE_POR 8'h0C

// status register fields
`define RSC_B_TO 1
`define RSC_B_PD 0

// sequencer status fields
`define RSC_B_HOLD 0
`define RSC_B_STARTUP 1
`define RSC_B_PUT_BUSY 2

// control register fields and reset value
`define RSC_B_PUT_EN_N 0
`define RSC_B_PIN_EN 1
`define RSC_B_STK_EN 2
`define RSC_B_OSC_REQ 3
`define RSC_CTRL_RESET 8'h06

// program counter vectors
`define RSC_PC_W 16
`define RSC_VEC_RESET 16'h0000
`define RSC_VEC_IRQ 16'h0004

`endif

/* core/rsc_delay_timer.v */
// one-shot down counter used as the power-up delay timer
`include "rsc_defs.vh"

module rsc_delay_timer #(
	parameter WIDTH = `RSC_PUT_WIDTH,
	parameter CYCLES = `RSC_PUT_CYCLES
) (
	// clock and reset
	input wire clock,
	input wire rst,
	// control
	input wire start,
	// status
	output reg busy,
	output reg done
);

	reg [WIDTH-1:0] count_reg;

	////////////////////////////////////////////////////////////////////////
	// counter: a new start always reloads, even mid-count
	always @(posedge clock) begin
		if (rst) begin
			count_reg <= {WIDTH{1'b0}};
			busy <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			count_reg <= CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy) begin
			if (count_reg == {WIDTH{1'b0}}) begin
				busy <= 1'b0;
				done <= 1'b1;
			end else begin
				count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

/* testbench/rsc_reset_seq_assertions.sv */
// concurrent checks on the reset sequencer ports
module rsc_reset_checker (
	// clock and reset
	input wire clock,
	input wire rst,
	// register read side
	input wire [3:0] reg_addr,
	input wire reg_rd,
	input wire [7:0] reg_rd_data,
	// reset sources and context
	input wire por_active,
	input wire bor_active,
	input wire prog_exit,
	input wire ext_reset_pin,
	input wire wdt_expired,
	input wire reset_instr_exec,
	input wire irq_wake,
	input wire in_sleep,
	input wire global_irq_enable,
	// core control and flags
	input wire core_hold,
	input wire pc_load,
	input wire [15:0] pc_load_addr,
	input wire wake_continue,
	input wire push_return,
	input wire watchdog_timeout_flag,
	input wire sleep_entry_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// soft events only count while running, with no power event pending
	wire run_ok = !core_hold && !por_active && !bor_active && !prog_exit && ext_reset_pin;
	////////////////////////////////////////////////////////////////
	chk_reset_vector: assert property (
		pc_load && !push_return |-> pc_load_addr == 16'h0000) else $error("bad restart vector");
	chk_irq_vector: assert property (
		push_return |-> pc_load && pc_load_addr == 16'h0004) else $error("bad irq vector");
	chk_power_hold: assert property (
		por_active || bor_active |=> core_hold) else $error("power event not held");
	chk_restart_path: assert property (
		$fell(core_hold) |-> $past(pc_load)) else $error("run without pc load");
	chk_instr_restart: assert property (
		run_ok && reset_instr_exec |=> core_hold && pc_load) else $error("no instr restart");
	chk_wdt_wake: assert property (
		run_ok && in_sleep && wdt_expired |=> wake_continue && !watchdog_timeout_flag
		&& !sleep_entry_flag) else $error("bad watchdog wake");
	chk_irq_wake: assert property (
		run_ok && in_sleep && irq_wake && !wdt_expired |=> wake_continue
		&& watchdog_timeout_flag && !sleep_entry_flag && push_return == global_irq_enable)
		else $error("bad irq wake");
	chk_gap_bits: assert property (
		reg_rd_data[5:4] == 2'b00) else $error("gap bits set");
	chk_status_read: assert property (
		reg_rd && reg_addr == 4'h1 |=> reg_rd_data == {6'h00, $past(watchdog_timeout_flag),
		$past(sleep_entry_flag)}) else $error("bad status read");
endmodule

/* testbench/rsc_supply_model.sv */
// supply supervisor and reset pin driver facing the sequencer
module rsc_supply_model (
	// clock
	input wire clock,
	// supply and pin
	output logic por_active,
	output logic bor_active,
	output logic ext_reset_pin,
	output logic osc_start_done
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		por_active = 1'b0;
		bor_active = 1'b0;
		ext_reset_pin = 1'b1;
		osc_start_done = 1'b1;
	end
	// dip of b cycles; pin held low p cycles from the same edge
	task dip(input int b, input int p);
		for (int i = 0; i < p; i++) begin
			@(posedge clock);
			bor_active <= i < b;
			ext_reset_pin <= 1'b0;
		end
		@(posedge clock);
		bor_active <= 1'b0;
		// weak pull-up: a released pin reads high
		ext_reset_pin <= 1'b1;
	endtask
endmodule

/* testbench/tb_rsc_reset_seq.sv */
// self-checking bench for the reset sequencer
module tb_rsc_reset_seq;
	timeunit 1ns;
	timeprecision 1ns;
	// short power-up delay keeps the run brief
	localparam int P = 20;
	logic clock, rst, reg_wr, reg_rd, in_sleep, global_irq_enable;
	logic [3:0] reg_addr;
	logic [7:0] reg_wr_data;
	logic [5:0] ev;
	wire [7:0] reg_rd_data;
	wire [15:0] pc_load_addr;
	wire por_active, bor_active, ext_reset_pin, osc_start_done;
	wire core_hold, pc_load, wake_continue, push_return;
	wire watchdog_timeout_flag, sleep_entry_flag;
	wire prog_exit = ev[0];
	wire wdt_expired = ev[1];
	wire reset_instr_exec = ev[2];
	wire stack_overflow = ev[3];
	wire stack_underflow = ev[4];
	wire irq_wake = ev[5];
	int failures = 0;
	int total_checks = 0;
	int n;
	rsc_reset_seq #(.PUT_CYCLES(P), .PUT_WIDTH(20)) dut (.*);
	rsc_supply_model sup (.*);
	////////////////////////////////////////////////////////////////
	task close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rdc(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rd_data, exp);
	endtask
	task pulse(input int i);
		@(posedge clock);
		ev[i] <= 1'b1;
		@(posedge clock);
		ev <= 6'h00;
	endtask
	// counts held cycles; the watchdog catches a hang
	task settle;
		n = 0;
		#1;
		while (core_hold !== 1'b0) begin
			@(posedge clock);
			#1 n++;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task t_por;
		settle;
		chk(n >= P && n <= P + 6, 16'h0001);
		rdc(4'h0, 8'h0C);
		rdc(4'h1, 8'h03);
		rdc(4'h3, 8'h06);
		rdc(4'hF, 8'h00);
		$display("por done");
	endtask
	task t_flags;
		wr(4'h0, 8'hFF);
		rdc(4'h0, 8'hCF);
		wr(4'h0, 8'h0F);
		pulse(2);
		settle;
		rdc(4'h0, 8'h0B);
		wr(4'h0, 8'h0F);
		pulse(3);
		settle;
		rdc(4'h0, 8'h8F);
		pulse(4);
		settle;
		rdc(4'h0, 8'hCF);
		wr(4'h3, 8'h02);
		wr(4'h0, 8'h0F);
		pulse(3);
		repeat (3) @(posedge clock);
		rdc(4'h0, 8'h0F);
		wr(4'h3, 8'h06);
		$display("flags done");
	endtask
	task t_sleep;
		pulse(1);
		settle;
		rdc(4'h1, 8'h01);
		@(posedge clock);
		in_sleep <= 1'b1;
		pulse(5);
		#1 chk(pc_load_addr, 16'h0004);
		rdc(4'h1, 8'h02);
		pulse(1);
		rdc(4'h1, 8'h00);
		sup.dip(0, 5);
		settle;
		rdc(4'h1, 8'h02);
		rdc(4'h0, 8'h07);
		@(posedge clock);
		in_sleep <= 1'b0;
		wr(4'h0, 8'h0F);
		sup.dip(0, 5);
		settle;
		rdc(4'h0, 8'h07);
		rdc(4'h1, 8'h02);
		$display("sleep done");
	endtask
	task t_brownout;
		wr(4'h0, 8'hC2);
		sup.dip(3, P + 23);
		settle;
		chk(n <= 3, 16'h0001);
		rdc(4'h0, 8'h0E);
		rdc(4'h1, 8'h03);
		$display("brownout done");
	endtask
	task t_config;
		wr(4'h3, 8'h0F);
		@(posedge clock);
		sup.osc_start_done <= 1'b0;
		pulse(0);
		repeat (10) @(posedge clock);
		#1 chk(core_hold, 16'h0001);
		rdc(4'h2, 8'h07);
		@(posedge clock);
		sup.osc_start_done <= 1'b1;
		settle;
		chk(n <= 3, 16'h0001);
		wr(4'h3, 8'h05);
		wr(4'h0, 8'h0F);
		sup.dip(0, 5);
		repeat (2) @(posedge clock);
		#1 chk(core_hold, 16'h0000);
		rdc(4'h0, 8'h0F);
		wr(4'h3, 8'h06);
		$display("config done");
	endtask
	task t_prog;
		pulse(1);
		settle;
		wr(4'h0, 8'hC2);
		pulse(0);
		settle;
		chk(n >= P, 16'h0001);
		rdc(4'h0, 8'h0C);
		rdc(4'h1, 8'h03);
		$display("prog exit done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		#400000;
		failures++;
		close_out;
	end
	initial begin
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wr_data = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ev = 6'h00;
		in_sleep = 1'b0;
		global_irq_enable = 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		t_por;
		t_flags;
		t_sleep;
		t_brownout;
		t_config;
		t_prog;
		close_out;
	end
endmodule
bind rsc_reset_seq rsc_reset_checker chk_i (.*);
